// File: sas_map.svh
/*
 * Register offsets, field positions, reset values and converter cycle counts
 * of the converter sequencer. Assumes byte addresses on a 32-bit Wishbone bus.
 */
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define SAS_OFF_MUX 8'h00
`define SAS_OFF_CTRLA 8'h04
`define SAS_OFF_CTRLB 8'h08
`define SAS_OFF_RESL 8'h0c
`define SAS_OFF_RESH 8'h10
`define SAS_OFF_PWR 8'h14

// ****************************************
// Field positions
// ****************************************
`define SAS_MUX_REF_HI 7
`define SAS_MUX_REF_LO 6
`define SAS_MUX_LADJ 5
`define SAS_MUX_CHAN_HI 3
`define SAS_A_EN 7
`define SAS_A_START 6
`define SAS_A_AUTO 5
`define SAS_A_FLAG 4
`define SAS_A_IE 3
`define SAS_A_PS_HI 2
`define SAS_B_SRC_HI 2
`define SAS_PWR_RED 0

// ****************************************
// Reset values
// ****************************************
`define SAS_RST_PWR 1'b0

// ****************************************
// Converter clock counts (counted in completed converter cycles) and the free-running trigger source
// ****************************************
`define SAS_NORMAL_DONE 5'h0c
`define SAS_FIRST_DONE 5'h18
`define SAS_AUTO_DONE 5'h0d
`define SAS_NORMAL_SAMPLE 5'h01
`define SAS_FIRST_SAMPLE 5'h0d
`define SAS_AUTO_SAMPLE 5'h01
`define SAS_FREE_RUN_SRC 3'h0

`endif

// File: sas_pkg.sv
/*
 * Types of the converter sequencer: state enum and the packed state record.
 * Assumes sas_map.svh supplies all numeric constants.
 */
package sas_pkg;

    typedef enum logic {SAS_IDLE, SAS_CONV} sas_phase_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [1:0] ref_sel;
        logic ladj;
        logic [3:0] chan_sel;
        logic en;
        logic start;
        logic auto_en;
        logic flag;
        logic ie;
        logic [2:0] ps;
        logic [2:0] src;
        logic pwr_red;
        logic [1:0] work_ref;
        logic [3:0] work_chan;
        logic [9:0] result;
        logic lock;
        logic first;
        sas_phase_t phase;
        logic is_auto;
        logic [4:0] cnt;
        logic [6:0] pre;
        logic pend;
        logic [7:0] trig_prev;
        logic [9:0] data_s1;
        logic [9:0] data_s2;
        logic sample;
    } sas_state_t;

endpackage : sas_pkg

// File: sas_sequencer.sv
/*
 * Control and sequencing logic of a 10-bit successive-approximation converter
 * with a classic Wishbone register slave. Assumes the analog side presents a
 * settled code on conv_data_in before completion, and trigger inputs come
 * from logic on ref_clk_in.
 */
`timescale 1ns/100ps
`include "sas_map.svh"

// How it works
// R01: 10-bit result, right or left justified
// R02: Low-byte read locks results until high read
// R03: Flag still set when locked result dropped
// R04: Start bit reads one while converting
// R05: Channel change applies after current conversion
// R06: Trigger edge resets prescaler, starts conversion
// R07: Edges during conversion ignored, no level restart
// R08: Software clears trigger flag for next event
// R09: Own done flag restarts immediately, always
// R10: Software starts first free-running conversion
// R11: Start bit works with auto-trigger on
// R12: Prescaler divides, held reset while disabled
// R13: Software start waits for converter clock edge
// R14: 13 cycles normal, 25 first after enable
// R15: Sample at 1.5, or 13.5 first
// R16: Completion writes result, flag, clears start except when free running
// R17: Auto sample at 2, done at 13.5
// R18: Selections effective only when enabled, else unpowered
// R19: Eight channels, ground or bandgap selectable
// R20: Code zero ground, max reference minus LSB
// R21: Power reduction bit must be cleared
// R22: Working selection copied when idle, last cycle
// R23: Three-bit divider, ratios two to 128
module sas_sequencer (
    input wire logic ref_clk_in, // 100 MHz clock
    input wire logic rstn_in, // Async reset, active low
    input wire logic wb_cyc_in, // Bus cycle
    input wire logic wb_stb_in, // Strobe
    input wire logic wb_we_in, // Write enable
    input wire logic [7:0] wb_adr_in, // Byte address
    input wire logic [3:0] wb_sel_in, // Byte selects
    input wire logic [31:0] wb_dat_in, // Write data
    output logic [31:0] wb_dat_out, // Read data
    output logic wb_ack_out, // Acknowledge
    input wire logic [7:0] trig_in, // Trigger sources
    input wire logic [9:0] conv_data_in, // Code from analog core
    output logic analog_on_out, // Analog power enable
    output logic [3:0] chan_sel_out, // Working channel select
    output logic [1:0] ref_sel_out, // Working reference select
    output logic sample_out, // Sample-and-hold pulse
    output logic conv_active_out, // Conversion running
    output logic done_irq_out // Completion interrupt request
);

    // ****************************************
    // Helpers
    // ****************************************
    // Ratios 2,2,4..128; divider minus one
    function automatic logic [6:0] sas_div_m1(input logic [2:0] ps);
        logic [7:0] d;
        d = 8'h01 << ps;
        if (ps == 3'h0)
        begin
            d = 8'h02;
        end
        return 7'(d - 8'h01); // R23
    endfunction : sas_div_m1

    function automatic logic [7:0] sas_read(input sas_pkg::sas_state_t s, input logic [7:0] adr);
        logic [15:0] j;
        j = s.ladj ? {s.result, 6'h00} : {6'h00, s.result}; // R01
        case (adr)
            `SAS_OFF_MUX: return {s.ref_sel, s.ladj, 1'b0, s.chan_sel};
            `SAS_OFF_CTRLA: return {s.en, s.start, s.auto_en, s.flag, s.ie, s.ps}; // R04
            `SAS_OFF_CTRLB: return {5'h00, s.src};
            `SAS_OFF_RESL: return j[7:0];
            `SAS_OFF_RESH: return j[15:8];
            `SAS_OFF_PWR: return {7'h00, s.pwr_red};
            default: return 8'h00;
        endcase
    endfunction : sas_read

    // ****************************************
    // State
    // ****************************************
    sas_pkg::sas_state_t st_reg;
    sas_pkg::sas_state_t st_next;

    logic req;
    logic wr;
    logic rd;
    logic [6:0] m1;
    logic tick;
    logic half;
    logic en_eff;
    logic trig_edge;
    logic sw_start;
    logic [4:0] done_cnt;
    logic done;
    logic free_run;

    always_comb
    begin
        st_next = st_reg;
        req = wb_cyc_in && wb_stb_in && !st_reg.ack;
        wr = req && wb_we_in && wb_sel_in[0];
        rd = req && !wb_we_in;
        m1 = sas_div_m1(st_reg.ps);
        tick = (st_reg.pre == m1);
        half = (st_reg.pre == (m1 >> 1));
        en_eff = st_reg.en && !st_reg.pwr_red; // R18 R21
        free_run = st_reg.auto_en && (st_reg.src == `SAS_FREE_RUN_SRC);
        trig_edge = 1'b0;
        sw_start = 1'b0;
        done = 1'b0;
        done_cnt = `SAS_NORMAL_DONE;

        // Bus slave, one wait state, unmapped reads give zero
        st_next.ack = req;
        st_next.sample = 1'b0;
        if (req)
        begin
            st_next.dat = {24'h000000, sas_read(st_reg, wb_adr_in)};
        end
        if (rd && wb_adr_in == `SAS_OFF_RESL)
        begin
            st_next.lock = 1'b1; // R02
        end
        if (rd && wb_adr_in == `SAS_OFF_RESH)
        begin
            st_next.lock = 1'b0; // R02
        end
        if (wr)
        begin
            case (wb_adr_in)
                `SAS_OFF_MUX:
                begin
                    st_next.ref_sel = wb_dat_in[`SAS_MUX_REF_HI:`SAS_MUX_REF_LO];
                    st_next.ladj = wb_dat_in[`SAS_MUX_LADJ];
                    st_next.chan_sel = wb_dat_in[`SAS_MUX_CHAN_HI:0]; // R19
                end
                `SAS_OFF_CTRLA:
                begin
                    st_next.en = wb_dat_in[`SAS_A_EN];
                    st_next.auto_en = wb_dat_in[`SAS_A_AUTO];
                    st_next.ie = wb_dat_in[`SAS_A_IE];
                    st_next.ps = wb_dat_in[`SAS_A_PS_HI:0]; // R23
                    sw_start = wb_dat_in[`SAS_A_START]; // R11
                    if (wb_dat_in[`SAS_A_FLAG])
                    begin
                        st_next.flag = 1'b0; // R08
                    end
                end
                `SAS_OFF_CTRLB:
                begin
                    st_next.src = wb_dat_in[`SAS_B_SRC_HI:0];
                end
                `SAS_OFF_PWR:
                begin
                    st_next.pwr_red = wb_dat_in[`SAS_PWR_RED];
                end
                default:
                begin
                    st_next.pwr_red = st_reg.pwr_red;
                end
            endcase
        end

        // Prescaler, free counting while enabled
        st_next.pre = tick ? 7'h00 : 7'(st_reg.pre + 7'h01); // R12
        st_next.trig_prev = trig_in;
        st_next.data_s1 = conv_data_in;
        st_next.data_s2 = st_reg.data_s1;

        // Edge on the chosen source; source zero is the own done flag
        if (st_reg.auto_en && st_reg.src != `SAS_FREE_RUN_SRC)
        begin
            trig_edge = trig_in[st_reg.src] && !st_reg.trig_prev[st_reg.src]; // R06
        end

        if (sw_start && en_eff)
        begin
            st_next.pend = 1'b1;
            st_next.start = 1'b1; // R04
        end

        case (st_reg.phase)
            sas_pkg::SAS_IDLE:
            begin
                // R22: working selection follows software while idle
                st_next.work_ref = st_reg.ref_sel;
                st_next.work_chan = st_reg.chan_sel;
                if (trig_edge && en_eff)
                begin
                    st_next.pre = 7'h00; // R06
                    st_next.phase = sas_pkg::SAS_CONV;
                    st_next.is_auto = 1'b1;
                    st_next.cnt = 5'h00;
                    st_next.start = 1'b1; // R04
                    st_next.pend = 1'b0;
                end
                else if (st_reg.pend && tick)
                begin
                    st_next.phase = sas_pkg::SAS_CONV; // R13
                    st_next.is_auto = 1'b0;
                    st_next.cnt = 5'h00;
                    st_next.pend = 1'b0;
                end
            end
            sas_pkg::SAS_CONV:
            begin
                // Selection frozen here so sampling sees one channel R05
                if (st_reg.first)
                begin
                    done_cnt = `SAS_FIRST_DONE; // R14
                end
                else if (st_reg.is_auto)
                begin
                    done_cnt = `SAS_AUTO_DONE; // R17
                end
                if (st_reg.cnt == done_cnt)
                begin
                    st_next.work_ref = st_reg.ref_sel; // R22
                    st_next.work_chan = st_reg.chan_sel;
                end
                if (tick)
                begin
                    st_next.cnt = 5'(st_reg.cnt + 5'h01);
                end
                if (st_reg.first)
                begin
                    st_next.sample = half && st_reg.cnt == `SAS_FIRST_SAMPLE; // R15
                    done = tick && st_reg.cnt == `SAS_FIRST_DONE; // R14
                end
                else if (st_reg.is_auto)
                begin
                    st_next.sample = tick && st_reg.cnt == `SAS_AUTO_SAMPLE; // R17
                    done = half && st_reg.cnt == `SAS_AUTO_DONE; // R17
                end
                else
                begin
                    st_next.sample = half && st_reg.cnt == `SAS_NORMAL_SAMPLE; // R15
                    done = tick && st_reg.cnt == `SAS_NORMAL_DONE; // R14
                end
                if (done)
                begin
                    st_next.first = 1'b0;
                    st_next.flag = 1'b1; // R03 R16
                    if (!st_reg.lock)
                    begin
                        st_next.result = st_reg.data_s2; // R02 R20
                    end
                    if (free_run)
                    begin
                        // R09: restart without waiting on the flag
                        st_next.cnt = 5'h00;
                        st_next.is_auto = 1'b0;
                        st_next.start = 1'b1;
                    end
                    else
                    begin
                        // R07: a trigger still high does not restart
                        st_next.phase = sas_pkg::SAS_IDLE;
                        st_next.start = st_reg.pend || (sw_start && en_eff); // R16
                    end
                end
            end
            default:
            begin
                st_next.phase = sas_pkg::SAS_IDLE;
            end
        endcase

        // Disabled: prescaler and sequencing held in reset
        if (!en_eff)
        begin
            st_next.pre = 7'h00; // R12
            st_next.phase = sas_pkg::SAS_IDLE;
            st_next.start = 1'b0;
            st_next.pend = 1'b0;
            st_next.first = 1'b1; // R14
            st_next.sample = 1'b0;
            st_next.work_ref = st_reg.ref_sel;
            st_next.work_chan = st_reg.chan_sel;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_reg <= '{
                ack: 1'b0,
                dat: 32'h00000000,
                ref_sel: 2'h0,
                ladj: 1'b0,
                chan_sel: 4'h0,
                en: 1'b0,
                start: 1'b0,
                auto_en: 1'b0,
                flag: 1'b0,
                ie: 1'b0,
                ps: 3'h0,
                src: 3'h0,
                pwr_red: `SAS_RST_PWR,
                work_ref: 2'h0,
                work_chan: 4'h0,
                result: 10'h000,
                lock: 1'b0,
                first: 1'b1,
                phase: sas_pkg::SAS_IDLE,
                is_auto: 1'b0,
                cnt: 5'h00,
                pre: 7'h00,
                pend: 1'b0,
                trig_prev: 8'h00,
                data_s1: 10'h000,
                data_s2: 10'h000,
                sample: 1'b0
            };
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Analog side sees selections only while powered
    assign analog_on_out = st_reg.en && !st_reg.pwr_red; // R18
    assign chan_sel_out = analog_on_out ? st_reg.work_chan : 4'h0; // R18
    assign ref_sel_out = analog_on_out ? st_reg.work_ref : 2'h0; // R18
    assign sample_out = st_reg.sample;
    assign conv_active_out = (st_reg.phase == sas_pkg::SAS_CONV);
    assign done_irq_out = st_reg.flag && st_reg.ie; // R03
    assign wb_dat_out = st_reg.dat;
    assign wb_ack_out = st_reg.ack;

endmodule : sas_sequencer

// File: sas_analog_model.sv
/* Behavioural analog core facing the sequencer.
   Assumes the sample pulse and selections come from the sequencer. */
`timescale 1ns/100ps
module sas_analog_model (
    input wire logic clk_in, // System clock
    input wire logic on_in, // Analog power
    input wire logic sample_in, // Sample-and-hold pulse
    input wire logic [3:0] chan_in, // Working channel
    input wire logic [1:0] ref_in, // Working reference
    output logic [9:0] code_out // Converted code
);
    logic [9:0] held = 10'h000;
    logic [9:0] junk = 10'h000;
    // Code held from the sample instant, as a real hold capacitor does
    always @(posedge clk_in)
    begin
        junk <= junk + 10'h155;
        if (sample_in)
            held <= {ref_in, chan_in, 4'ha};
    end
    // Unpowered core shows a moving pattern, never a stale code
    assign code_out = on_in ? held : junk;
endmodule : sas_analog_model

// File: sas_sequencer_properties.sv
/* Port-level assertions of the converter sequencer.
   Assumes the bench runs the prescaler at its fastest ratio. */
`timescale 1ns/100ps
module sas_sequencer_properties (
    input wire logic ref_clk_in, // Clock
    input wire logic rstn_in, // Reset, active low
    input wire logic wb_cyc_in, // Bus cycle
    input wire logic wb_stb_in, // Strobe
    input wire logic wb_ack_out, // Acknowledge
    input wire logic analog_on_out, // Analog power
    input wire logic [3:0] chan_sel_out, // Working channel
    input wire logic [1:0] ref_sel_out, // Working reference
    input wire logic sample_out, // Sample pulse
    input wire logic conv_active_out // Converting
);
    logic [7:0] run_len;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    always_ff @(posedge ref_clk_in or negedge rstn_in)
        if (!rstn_in)
            run_len <= 8'h00;
        else
            run_len <= conv_active_out ? run_len + 8'h01 : 8'h00;
    property p_ack_lat;
        wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
    endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack late");
    property p_ack_pulse;
        wb_ack_out |=> !wb_ack_out;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_off_sel;
        !analog_on_out |-> chan_sel_out == 4'h0 && ref_sel_out == 2'h0;
    endproperty
    a_off_sel: assert property (p_off_sel) else $error("selection while off");
    property p_off_stop;
        !analog_on_out |=> !conv_active_out;
    endproperty
    a_off_stop: assert property (p_off_stop) else $error("converting while off");
    property p_hold;
        $rose(conv_active_out) |=> ($stable(chan_sel_out) || !analog_on_out) [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("channel moved");
    property p_samp_in;
        sample_out |-> conv_active_out;
    endproperty
    a_samp_in: assert property (p_samp_in) else $error("sample outside");
    property p_samp_late;
        $rose(conv_active_out) |-> !sample_out [*2];
    endproperty
    a_samp_late: assert property (p_samp_late) else $error("sample early");
    property p_len;
        $fell(conv_active_out) && analog_on_out |-> run_len >= 8'd24 && run_len <= 8'd52;
    endproperty
    a_len: assert property (p_len) else $error("bad length");
endmodule : sas_sequencer_properties
bind sas_sequencer sas_sequencer_properties u_props (
    .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .analog_on_out(analog_on_out),
    .chan_sel_out(chan_sel_out), .ref_sel_out(ref_sel_out), .sample_out(sample_out),
    .conv_active_out(conv_active_out)
);

// File: sas_sequencer_tb_top.sv
/* Register-level tests of the converter sequencer over classic Wishbone.
   Assumes the analog model and prescale 0 (divide by two). */
`timescale 1ns/100ps
`include "sas_map.svh"
module sas_sequencer_tb_top;
    logic clk, rstn, cyc, stb, we, ack, on, samp, act, irq, act_q;
    logic [7:0] adr, trig, q, rises, rises0, run_len, last_len, first_len;
    logic [3:0] sel, chan;
    logic [31:0] dw, dr;
    logic [9:0] code;
    logic [1:0] rsel;
    logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    sas_sequencer DUT (
        .ref_clk_in(clk), .rstn_in(rstn), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dw),
        .wb_dat_out(dr), .wb_ack_out(ack), .trig_in(trig), .conv_data_in(code),
        .analog_on_out(on), .chan_sel_out(chan), .ref_sel_out(rsel),
        .sample_out(samp), .conv_active_out(act), .done_irq_out(irq)
    );
    sas_analog_model u_analog (
        .clk_in(clk), .on_in(on), .sample_in(samp), .chan_in(chan), .ref_in(rsel), .code_out(code)
    );
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        act_q <= act;
        run_len <= act ? run_len + 8'h01 : 8'h00;
        if (act_q && !act)
            last_len <= run_len;
        // One sample pulse per conversion; free running keeps act high
        if (!rstn)
            rises <= 8'h00;
        else if (samp)
            rises <= rises + 8'h01;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            final_report();
        end
    end
    // ****************
    // Tasks
    // ****************
    task final_report();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task cmp(input string what, input logic [9:0] exp, input logic [9:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // Request held until ack is sampled high at a rising edge
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        q = dr[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20)
            cmp("ack", 10'h1, 10'h0);
    endtask : wb
    task chk(input logic [7:0] a, input logic [7:0] e, input string what);
        wb(1'b0, a, 8'h00);
        cmp(what, {2'b0, e}, {2'b0, q});
    endtask : chk
    task idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    task wait_single();
        int k;
        k = 0;
        q = 8'h40;
        while (q[6] === 1'b1 && k < 60)
        begin
            wb(1'b0, `SAS_OFF_CTRLA, 8'h00);
            k++;
        end
        cmp("start clear", 10'h0, {9'h0, q[6]});
        idle(3);
    endtask : wait_single
    // ****************
    // Tests
    // ****************
    initial
    begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h1;
        dw = 32'h0;
        trig = 8'h00;
        rstn = 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        foreach (offs[i])
            chk(offs[i], 8'h00, "reset value");
        wb(1'b1, `SAS_OFF_RESL, 8'hff);
        wb(1'b1, 8'h18, 8'hff);
        chk(`SAS_OFF_RESL, 8'h00, "read only");
        chk(8'h18, 8'h00, "unmapped");
        chk(`SAS_OFF_RESH, 8'h00, "unlock");
        $display("test reset done");
        wb(1'b1, `SAS_OFF_MUX, 8'h43);
        wb(1'b1, `SAS_OFF_CTRLA, 8'h88);
        wb(1'b1, `SAS_OFF_CTRLA, 8'hc8);
        chk(`SAS_OFF_CTRLA, 8'hc8, "busy");
        wb(1'b1, `SAS_OFF_MUX, 8'h85);
        wait_single();
        chk(`SAS_OFF_CTRLA, 8'h98, "done");
        cmp("irq", 10'h1, {9'h0, irq});
        first_len = last_len;
        chk(`SAS_OFF_RESL, 8'h3a, "old chan low");
        chk(`SAS_OFF_RESH, 8'h01, "old chan high");
        wb(1'b1, `SAS_OFF_CTRLA, 8'hd8);
        wait_single();
        cmp("first longer", 10'h1, {9'h0, (first_len - last_len) inside {[8'd23:8'd25]}});
        chk(`SAS_OFF_RESL, 8'h5a, "new chan low");
        wb(1'b1, `SAS_OFF_MUX, 8'h43);
        wb(1'b1, `SAS_OFF_CTRLA, 8'hd8);
        wait_single();
        chk(`SAS_OFF_CTRLA, 8'h98, "locked flag");
        chk(`SAS_OFF_RESH, 8'h02, "locked high");
        chk(`SAS_OFF_RESL, 8'h5a, "kept low");
        chk(`SAS_OFF_RESH, 8'h02, "unlock high");
        wb(1'b1, `SAS_OFF_MUX, 8'h63);
        wb(1'b1, `SAS_OFF_CTRLA, 8'hd8);
        wait_single();
        chk(`SAS_OFF_RESL, 8'h80, "left low");
        chk(`SAS_OFF_RESH, 8'h4e, "left high");
        $display("test single done");
        wb(1'b1, `SAS_OFF_CTRLB, 8'h02);
        wb(1'b1, `SAS_OFF_CTRLA, 8'hb8);
        rises0 = rises;
        trig <= 8'h08;
        idle(8);
        cmp("other source", {2'b0, rises0}, {2'b0, rises});
        trig <= 8'h0c;
        idle(6);
        cmp("trigger start", 10'h1, {9'h0, act});
        trig <= 8'h08;
        idle(2);
        trig <= 8'h0c;
        idle(80);
        cmp("one conversion", {2'b0, rises0 + 8'h01}, {2'b0, rises});
        wb(1'b1, `SAS_OFF_CTRLA, 8'hf8);
        idle(80);
        cmp("soft start", {2'b0, rises0 + 8'h02}, {2'b0, rises});
        $display("test auto done");
        wb(1'b1, `SAS_OFF_CTRLB, 8'h00);
        wb(1'b1, `SAS_OFF_CTRLA, 8'he8);
        idle(130);
        cmp("free run", 10'h1, {9'h0, rises >= rises0 + 8'h06});
        chk(`SAS_OFF_CTRLA, 8'hf8, "still busy");
        wb(1'b1, `SAS_OFF_CTRLA, 8'h00);
        idle(3);
        cmp("off", 10'h0, {on, act, chan, rsel, 2'b0});
        $display("test free done");
        wb(1'b1, `SAS_OFF_PWR, 8'h01);
        wb(1'b1, `SAS_OFF_CTRLA, 8'hc8);
        idle(10);
        cmp("gated", 10'h0, {8'h0, on, act});
        chk(`SAS_OFF_PWR, 8'h01, "power bit");
        $display("test power done");
        final_report();
    end
endmodule : sas_sequencer_tb_top
